// ==== rtl/adc_mode_and_config_control.sv ====
// Configuration word decode, mode sequencing and serial register access.
// Assumes the host drives link_sclk only inside frames and holds
// register_select_pin steady for a whole frame.

module adc_mode_and_config_control #(
  parameter int CYCLES_PER_CODE = adc_cfg_pkg::CLK_DIV_PER_CODE
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link
  input wire logic link_sclk,
  input wire logic tfs_n,
  input wire logic rfs_n,
  input wire logic register_select_pin,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  output logic result_ready_n,
  // Front end measurements
  input wire logic [23:0] filter_result,
  input wire logic [23:0] zero_measure,
  input wire logic [23:0] full_measure,
  // Front end controls
  output logic [7:0] pga_gain,
  output logic single_ended_input,
  output logic differential_input,
  output logic sleep_select,
  output logic result_width_select,
  output logic excitation_current_enable,
  output logic sensor_fault_current_enable,
  output logic unipolar_select,
  output logic [11:0] notch_code,
  output logic zero_on_shorted,
  output logic full_on_reference
);
  localparam int W = adc_cfg_pkg::CFG_W;
  localparam adc_cfg_pkg::cal_state_t ST_CONVERT = adc_cfg_pkg::ST_CONVERT;
  localparam adc_cfg_pkg::cal_state_t ST_CAL_ZERO = adc_cfg_pkg::ST_CAL_ZERO;
  localparam adc_cfg_pkg::cal_state_t ST_CAL_FULL = adc_cfg_pkg::ST_CAL_FULL;

  // ****************************************
  // Link domain: write capture
  // ****************************************
  logic wr_rst_n;
  logic [4:0] wr_cnt_ff, nxt_wr_cnt;
  logic [W-1:0] wr_shift_ff, nxt_wr_shift;
  logic [W-1:0] wr_word_ff, nxt_wr_word;
  logic wr_sel_ff, nxt_wr_sel;
  logic wr_tgl_ff, nxt_wr_tgl;

  // The bit count is cleared by the frame signal, so no edge is needed after a frame.
  assign wr_rst_n = reset_n & ~tfs_n;

  always_comb begin
    nxt_wr_cnt = wr_cnt_ff;
    nxt_wr_shift = {wr_shift_ff[W-2:0], sdata_in};
    nxt_wr_word = wr_word_ff;
    nxt_wr_sel = wr_sel_ff;
    nxt_wr_tgl = wr_tgl_ff;
    if (wr_cnt_ff < adc_cfg_pkg::XFER_BITS) begin
      nxt_wr_cnt = wr_cnt_ff + 5'h01;
      if (nxt_wr_cnt == adc_cfg_pkg::XFER_BITS) begin
        nxt_wr_word = nxt_wr_shift;
        nxt_wr_sel = register_select_pin;
        nxt_wr_tgl = ~wr_tgl_ff;
      end
    end else begin
      nxt_wr_shift = wr_shift_ff;
    end
  end

  always_ff @(posedge link_sclk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wr_cnt_ff <= 5'h00;
    end else begin
      wr_cnt_ff <= nxt_wr_cnt;
    end
  end

  always_ff @(posedge link_sclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_shift_ff <= 24'h00_0000;
      wr_word_ff <= 24'h00_0000;
      wr_sel_ff <= 1'b0;
      wr_tgl_ff <= 1'b0;
    end else begin
      wr_shift_ff <= nxt_wr_shift;
      wr_word_ff <= nxt_wr_word;
      wr_sel_ff <= nxt_wr_sel;
      wr_tgl_ff <= nxt_wr_tgl;
    end
  end

  // ****************************************
  // Link domain: read shift out
  // ****************************************
  logic rd_rst_n;
  logic [4:0] rd_cnt_ff, nxt_rd_cnt;
  logic rd_tgl_ff, nxt_rd_tgl;
  logic [W-1:0] rd_snap_ff;
  logic [4:0] rd_len_ff;
  logic rd_is_data_ff;

  assign rd_rst_n = reset_n & ~rfs_n;

  // The snapshot and length are frozen by the core while a read frame is open.
  always_comb begin
    nxt_rd_cnt = rd_cnt_ff;
    nxt_rd_tgl = rd_tgl_ff;
    if (rd_cnt_ff < rd_len_ff) begin
      nxt_rd_cnt = rd_cnt_ff + 5'h01;
      if (nxt_rd_cnt == rd_len_ff && rd_is_data_ff) begin
        nxt_rd_tgl = ~rd_tgl_ff;
      end
    end
  end

  always_ff @(negedge link_sclk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rd_cnt_ff <= 5'h00;
    end else begin
      rd_cnt_ff <= nxt_rd_cnt;
    end
  end

  always_ff @(negedge link_sclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_tgl_ff <= 1'b0;
    end else begin
      rd_tgl_ff <= nxt_rd_tgl;
    end
  end

  assign sdata_oe = ~rfs_n & (rd_cnt_ff < rd_len_ff);
  assign sdata_out = sdata_oe & rd_snap_ff[5'(W - 1) - rd_cnt_ff];

  // ****************************************
  // Crossings into the core domain
  // ****************************************
  logic [2:0] wr_sync_ff;
  logic [2:0] rd_sync_ff;
  logic [1:0] rfs_sync_ff;
  logic [1:0] sel_sync_ff;
  logic wr_event;
  logic rd_event;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
      rfs_sync_ff <= 2'h3;
      sel_sync_ff <= 2'h0;
    end else begin
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
      rfs_sync_ff <= {rfs_sync_ff[0], rfs_n};
      sel_sync_ff <= {sel_sync_ff[0], register_select_pin};
    end
  end

  assign wr_event = wr_sync_ff[2] ^ wr_sync_ff[1];
  assign rd_event = rd_sync_ff[2] ^ rd_sync_ff[1];

  // ****************************************
  // Core domain: registers and sequencing
  // ****************************************
  logic [W-1:0] cfg_ff, nxt_cfg;
  logic [W-1:0] zero_coeff_ff [2];
  logic [W-1:0] nxt_zero_coeff [2];
  logic [W-1:0] full_coeff_ff [2];
  logic [W-1:0] nxt_full_coeff [2];
  logic [W-1:0] result_ff, nxt_result;
  logic ready_n_ff, nxt_ready_n;
  adc_cfg_pkg::cal_state_t state_ff, nxt_state;
  logic [23:0] timer_ff, nxt_timer;
  logic [W-1:0] nxt_rd_snap;
  logic [4:0] nxt_rd_len;
  logic nxt_rd_is_data;
  logic [2:0] mode;
  logic ch;
  logic [11:0] notch_eff;
  logic [23:0] period;
  logic tick;
  logic cal_done;

  assign mode = cfg_ff[adc_cfg_pkg::MODE_HI:adc_cfg_pkg::MODE_LO];
  assign ch = cfg_ff[adc_cfg_pkg::INPUT_BIT];
  // A code below the legal floor is clamped so the timer never runs away.
  assign notch_eff = (cfg_ff[adc_cfg_pkg::NOTCH_HI:adc_cfg_pkg::NOTCH_LO] < adc_cfg_pkg::NOTCH_MIN) ?
                     adc_cfg_pkg::NOTCH_MIN : cfg_ff[adc_cfg_pkg::NOTCH_HI:adc_cfg_pkg::NOTCH_LO];
  assign period = (mode == adc_cfg_pkg::MODE_BACKGROUND) ?
                  24'(notch_eff * CYCLES_PER_CODE * adc_cfg_pkg::BG_RATE_FACTOR) :
                  24'(notch_eff * CYCLES_PER_CODE);
  assign tick = !cfg_ff[adc_cfg_pkg::SLEEP_BIT] && (timer_ff >= period - 24'h00_0001);

  always_comb begin
    nxt_timer = tick ? 24'h00_0000 : timer_ff + 24'h00_0001;
    if (cfg_ff[adc_cfg_pkg::SLEEP_BIT]) begin
      nxt_timer = 24'h00_0000;
    end
  end

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_zero_coeff = zero_coeff_ff;
    nxt_full_coeff = full_coeff_ff;
    nxt_result = result_ff;
    nxt_state = state_ff;
    nxt_ready_n = ready_n_ff;
    cal_done = 1'b0;
    if (rd_event) begin
      nxt_ready_n = 1'b1;
    end
    unique case (state_ff)
      ST_CONVERT: begin
        if (mode == adc_cfg_pkg::MODE_SELF_CAL || mode == adc_cfg_pkg::MODE_SYS_ZERO ||
            mode == adc_cfg_pkg::MODE_SYS_OFFSET) begin
          nxt_state = ST_CAL_ZERO;
        end else if (mode == adc_cfg_pkg::MODE_SYS_FULL) begin
          nxt_state = ST_CAL_FULL;
        end else if (tick) begin
          nxt_result = filter_result;
          nxt_ready_n = 1'b0;
          if (mode == adc_cfg_pkg::MODE_BACKGROUND) begin
            nxt_zero_coeff[ch] = zero_measure;
            nxt_full_coeff[ch] = full_measure;
          end
        end
      end
      ST_CAL_ZERO: begin
        if (tick) begin
          nxt_zero_coeff[ch] = zero_measure;
          if (mode == adc_cfg_pkg::MODE_SYS_ZERO) begin
            cal_done = 1'b1;
          end else begin
            nxt_state = ST_CAL_FULL;
          end
        end
      end
      ST_CAL_FULL: begin
        if (tick) begin
          nxt_full_coeff[ch] = full_measure;
          cal_done = 1'b1;
        end
      end
    endcase
    if (cal_done) begin
      nxt_state = ST_CONVERT;
      nxt_cfg[adc_cfg_pkg::MODE_HI:adc_cfg_pkg::MODE_LO] = adc_cfg_pkg::MODE_NORMAL;
      nxt_ready_n = 1'b0;
    end
    // A configuration write arriving with a calibration end is the newer command and wins.
    if (wr_event) begin
      if (!wr_sel_ff) begin
        nxt_cfg = wr_word_ff;
        nxt_state = ST_CONVERT;
      end else if (mode == adc_cfg_pkg::MODE_ZERO_COEFF) begin
        nxt_zero_coeff[ch] = wr_word_ff;
      end else if (mode == adc_cfg_pkg::MODE_FULL_COEFF) begin
        nxt_full_coeff[ch] = wr_word_ff;
      end
    end
  end

  // Read source is picked only while no read frame is open and frozen while one is open.
  always_comb begin
    nxt_rd_snap = rd_snap_ff;
    nxt_rd_len = rd_len_ff;
    nxt_rd_is_data = rd_is_data_ff;
    if (rfs_sync_ff[1]) begin
      nxt_rd_len = adc_cfg_pkg::XFER_BITS;
      nxt_rd_is_data = 1'b0;
      if (!sel_sync_ff[1]) begin
        nxt_rd_snap = cfg_ff;
      end else if (mode == adc_cfg_pkg::MODE_ZERO_COEFF) begin
        nxt_rd_snap = zero_coeff_ff[ch];
      end else if (mode == adc_cfg_pkg::MODE_FULL_COEFF) begin
        nxt_rd_snap = full_coeff_ff[ch];
      end else begin
        nxt_rd_snap = result_ff;
        nxt_rd_is_data = 1'b1;
        nxt_rd_len = cfg_ff[adc_cfg_pkg::WIDTH_BIT] ? adc_cfg_pkg::XFER_BITS : adc_cfg_pkg::SHORT_BITS;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= adc_cfg_pkg::CFG_RESET;
      zero_coeff_ff <= '{default: 24'h00_0000};
      full_coeff_ff <= '{default: 24'h00_0000};
      result_ff <= 24'h00_0000;
      ready_n_ff <= 1'b1;
      state_ff <= ST_CONVERT;
      timer_ff <= 24'h00_0000;
      rd_snap_ff <= 24'h00_0000;
      rd_len_ff <= adc_cfg_pkg::XFER_BITS;
      rd_is_data_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      zero_coeff_ff <= nxt_zero_coeff;
      full_coeff_ff <= nxt_full_coeff;
      result_ff <= nxt_result;
      ready_n_ff <= nxt_ready_n;
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      rd_snap_ff <= nxt_rd_snap;
      rd_len_ff <= nxt_rd_len;
      rd_is_data_ff <= nxt_rd_is_data;
    end
  end

  // ****************************************
  // Front end controls
  // ****************************************
  assign result_ready_n = ready_n_ff;
  assign pga_gain = 8'h01 << cfg_ff[adc_cfg_pkg::GAIN_HI:adc_cfg_pkg::GAIN_LO];
  assign single_ended_input = cfg_ff[adc_cfg_pkg::INPUT_BIT];
  assign differential_input = ~cfg_ff[adc_cfg_pkg::INPUT_BIT];
  assign sleep_select = cfg_ff[adc_cfg_pkg::SLEEP_BIT];
  assign result_width_select = cfg_ff[adc_cfg_pkg::WIDTH_BIT];
  assign excitation_current_enable = cfg_ff[adc_cfg_pkg::EXCITE_BIT];
  assign sensor_fault_current_enable = cfg_ff[adc_cfg_pkg::FAULT_BIT];
  assign unipolar_select = cfg_ff[adc_cfg_pkg::POLARITY_BIT];
  assign notch_code = cfg_ff[adc_cfg_pkg::NOTCH_HI:adc_cfg_pkg::NOTCH_LO];
  assign zero_on_shorted = (state_ff == ST_CAL_ZERO && mode == adc_cfg_pkg::MODE_SELF_CAL) ||
                           mode == adc_cfg_pkg::MODE_BACKGROUND;
  assign full_on_reference = (state_ff == ST_CAL_FULL) &&
                             (mode == adc_cfg_pkg::MODE_SELF_CAL || mode == adc_cfg_pkg::MODE_SYS_OFFSET);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence cal_end_s;
    state_ff != ST_CONVERT && tick && !wr_event && (state_ff == ST_CAL_FULL || mode == adc_cfg_pkg::MODE_SYS_ZERO);
  endsequence
  sequence back_normal_s;
    mode == adc_cfg_pkg::MODE_NORMAL && state_ff == ST_CONVERT && !result_ready_n;
  endsequence

  cfg_write_a: assert property (wr_event && !wr_sel_ff |=> cfg_ff == $past(wr_word_ff))
    else $error("configuration write not applied");
  self_cal_end_a: assert property (cal_end_s and mode == adc_cfg_pkg::MODE_SELF_CAL |=> back_normal_s)
    else $error("self calibration did not return to normal");
  cal_ready_a: assert property (cal_end_s |=> !result_ready_n)
    else $error("calibration end not flagged");
  sys_zero_a: assert property (cal_end_s and mode == adc_cfg_pkg::MODE_SYS_ZERO
                               |=> back_normal_s and zero_coeff_ff[ch] == $past(zero_measure))
    else $error("system zero step wrong");
  sys_full_a: assert property (cal_end_s and mode == adc_cfg_pkg::MODE_SYS_FULL
                               |=> back_normal_s and full_coeff_ff[ch] == $past(full_measure))
    else $error("system full step wrong");
  offset_ref_a: assert property (state_ff == ST_CAL_FULL && mode == adc_cfg_pkg::MODE_SYS_OFFSET
                                 |-> full_on_reference && !zero_on_shorted)
    else $error("offset calibration source wrong");
  bg_rate_a: assert property (mode == adc_cfg_pkg::MODE_BACKGROUND
                              |-> period == 24'(notch_eff * CYCLES_PER_CODE * adc_cfg_pkg::BG_RATE_FACTOR))
    else $error("background rate not reduced by six");
  gain_decode_a: assert property ($onehot(pga_gain) &&
                                  pga_gain == (8'h01 << cfg_ff[adc_cfg_pkg::GAIN_HI:adc_cfg_pkg::GAIN_LO]))
    else $error("gain decode wrong");
  sleep_halt_a: assert property (sleep_select |-> !tick ##1 timer_ff == 24'h00_0000)
    else $error("conversion ran while asleep");
  zero_coeff_a: assert property (wr_event && wr_sel_ff && mode == adc_cfg_pkg::MODE_ZERO_COEFF
                                 |=> zero_coeff_ff[$past(ch)] == $past(wr_word_ff))
    else $error("zero coefficient write lost");
  full_coeff_a: assert property (wr_event && wr_sel_ff && mode == adc_cfg_pkg::MODE_FULL_COEFF
                                 |=> full_coeff_ff[$past(ch)] == $past(wr_word_ff))
    else $error("full coefficient write lost");
endmodule : adc_mode_and_config_control

// ==== rtl/adc_cfg_pkg.sv ====
// Constants shared by the converter mode and configuration control.
// Assumes a single core clock and a serial link clock from the host.
package adc_cfg_pkg;
  // ****************************************
  // Configuration word layout
  // ****************************************
  localparam int CFG_W = 24;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 21;
  localparam int GAIN_HI = 20;
  localparam int GAIN_LO = 18;
  localparam int INPUT_BIT = 17;
  localparam int SLEEP_BIT = 16;
  localparam int WIDTH_BIT = 15;
  localparam int EXCITE_BIT = 14;
  localparam int FAULT_BIT = 13;
  localparam int POLARITY_BIT = 12;
  localparam int NOTCH_HI = 11;
  localparam int NOTCH_LO = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 24'h00_0000;

  // ****************************************
  // Operating modes
  // ****************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF_CAL = 3'h1;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
  localparam logic [2:0] MODE_SYS_FULL = 3'h3;
  localparam logic [2:0] MODE_SYS_OFFSET = 3'h4;
  localparam logic [2:0] MODE_BACKGROUND = 3'h5;
  localparam logic [2:0] MODE_ZERO_COEFF = 3'h6;
  localparam logic [2:0] MODE_FULL_COEFF = 3'h7;

  // ****************************************
  // Timing and lengths
  // ****************************************
  localparam logic [4:0] XFER_BITS = 5'h18;
  localparam logic [4:0] SHORT_BITS = 5'h10;
  localparam logic [11:0] NOTCH_MIN = 12'h013;
  localparam int CLK_DIV_PER_CODE = 512;
  localparam logic [2:0] BG_RATE_FACTOR = 3'h6;

  typedef enum logic [1:0] {ST_CONVERT, ST_CAL_ZERO, ST_CAL_FULL} cal_state_t;
endpackage : adc_cfg_pkg

// ==== sim/host_serial_model.sv ====
// Host model that drives the converter's serial link.
// Assumes the caller runs one frame at a time; the link clock idles low.
module host_serial_model (
  // Link outputs
  output logic link_sclk,
  output logic tfs_n,
  output logic rfs_n,
  output logic register_select_pin,
  output logic sdata_in,
  // Link inputs
  input wire logic sdata_out,
  input wire logic sdata_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 24ns;

  initial begin
    link_sclk = 1'b0;
    tfs_n = 1'b1;
    rfs_n = 1'b1;
    register_select_pin = 1'b0;
    sdata_in = 1'b0;
  end

  // ****************************************
  // Frames
  // ****************************************
  // Bits past the word carry a toggling pattern; the idle line is inverted once after the frame.
  task automatic write_frame(input logic sel, input logic [23:0] data, input int nbits);
    logic [23:0] word;
    word = data;
    if (!sel && (word[11:0] < 12'h013 || word[11:0] > 12'h7d0)) begin
      word[11:0] = 12'h013;
    end
    register_select_pin = sel;
    #(HALF);
    tfs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdata_in = (i < 24) ? word[23 - i] : ~sdata_in;
      #(HALF);
      link_sclk = 1'b1;
      #(HALF);
      link_sclk = 1'b0;
    end
    #(HALF);
    tfs_n = 1'b1;
    sdata_in = ~sdata_in;
    #(HALF * 5);
  endtask : write_frame

  // Bits taken while the device does not drive come back unknown.
  task automatic read_frame(input logic sel, input int nbits, output logic [23:0] data);
    data = 24'h00_0000;
    register_select_pin = sel;
    #(HALF);
    rfs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      #(HALF);
      link_sclk = 1'b1;
      data = {data[22:0], (sdata_oe === 1'b1) ? sdata_out : 1'bx};
      #(HALF);
      link_sclk = 1'b0;
    end
    #(HALF);
    rfs_n = 1'b1;
    #(HALF * 5);
  endtask : read_frame
endmodule : host_serial_model

// ==== sim/testbench.sv ====
// Self-checking bench for the mode and configuration control.
// Assumes the host model in host_serial_model and a shortened code period.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, reset_n, link_sclk, tfs_n, rfs_n, register_select_pin;
  logic sdata_in, sdata_out, sdata_oe, result_ready_n;
  logic [23:0] filter_result, zero_measure, full_measure, rd, w, ez, ef;
  logic [7:0] pga_gain;
  logic [11:0] notch_code;
  logic [5:0] fl;
  logic [2:0] m;
  logic single_ended_input, differential_input, sleep_select, result_width_select;
  logic excitation_current_enable, sensor_fault_current_enable, unipolar_select;
  logic zero_on_shorted, full_on_reference;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  adc_mode_and_config_control #(.CYCLES_PER_CODE(1)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .link_sclk(link_sclk), .tfs_n(tfs_n), .rfs_n(rfs_n), .register_select_pin(register_select_pin),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .result_ready_n(result_ready_n),
    .filter_result(filter_result), .zero_measure(zero_measure), .full_measure(full_measure),
    .pga_gain(pga_gain), .single_ended_input(single_ended_input), .differential_input(differential_input),
    .sleep_select(sleep_select), .result_width_select(result_width_select),
    .excitation_current_enable(excitation_current_enable),
    .sensor_fault_current_enable(sensor_fault_current_enable), .unipolar_select(unipolar_select),
    .notch_code(notch_code), .zero_on_shorted(zero_on_shorted), .full_on_reference(full_on_reference));

  host_serial_model host_u (.link_sclk(link_sclk), .tfs_n(tfs_n), .rfs_n(rfs_n),
    .register_select_pin(register_select_pin), .sdata_in(sdata_in), .sdata_out(sdata_out),
    .sdata_oe(sdata_oe));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({23'h00_0000, got}, {23'h00_0000, exp}, what);
  endtask : check_bit

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cycles

  task automatic set_front(input logic [23:0] fr, input logic [23:0] zm, input logic [23:0] fm);
    @(posedge ref_clk);
    #1;
    filter_result = fr;
    zero_measure = zm;
    full_measure = fm;
  endtask : set_front

  task automatic cfg(input logic [2:0] mode, input logic [5:0] flags, input logic [2:0] gain);
    w = {mode, gain, flags, 12'h013};
    host_u.write_frame(1'b0, w, 24);
  endtask : cfg

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    reset_n = 1'b0;
    filter_result = 24'h00_0000;
    zero_measure = 24'h00_0000;
    full_measure = 24'h00_0000;
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    wait_cycles(4);
    check_word({16'h0000, pga_gain}, 24'h00_0001, "gain at reset");
    check_bit(differential_input, 1'b1, "input at reset");
    check_bit(sleep_select, 1'b0, "sleep at reset");
    check_bit(result_width_select, 1'b0, "width at reset");
    check_bit(unipolar_select, 1'b0, "polarity at reset");
    host_u.read_frame(1'b0, 24, rd);
    check_word(rd, 24'h00_0000, "config at reset");
    for (int g = 0; g < 8; g++) begin
      fl = {g[0], g[1], g[2], ~g[0], ~g[1], g[0] ^ g[1]};
      w = {adc_cfg_pkg::MODE_NORMAL, g[2:0], fl, 12'h013 + 12'(g * 250)};
      host_u.write_frame(1'b0, w, 24);
      check_word({16'h0000, pga_gain}, 24'(1 << g), "gain");
      check_bit(single_ended_input, fl[5], "single input");
      check_bit(differential_input, ~fl[5], "diff input");
      check_bit(sleep_select, fl[4], "sleep");
      check_bit(result_width_select, fl[3], "width");
      check_bit(excitation_current_enable, fl[2], "excitation");
      check_bit(sensor_fault_current_enable, fl[1], "fault current");
      check_bit(unipolar_select, fl[0], "polarity");
      check_word({12'h000, notch_code}, {12'h000, w[11:0]}, "notch");
      host_u.read_frame(1'b0, 24, rd);
      check_word(rd, w, "config readback");
    end
    cfg(adc_cfg_pkg::MODE_NORMAL, 6'h00, 3'h2);
    host_u.write_frame(1'b0, 24'h5f_f100, 16);
    host_u.read_frame(1'b0, 24, rd);
    check_word(rd, w, "short write");
    w = 24'h0c_0013;
    host_u.write_frame(1'b0, w, 28);
    host_u.read_frame(1'b0, 24, rd);
    check_word(rd, w, "long write");
    cfg(adc_cfg_pkg::MODE_NORMAL, 6'h00, 3'h0);
    set_front(24'hab_cdef, 24'h00_0000, 24'h00_0000);
    wait_cycles(40);
    host_u.read_frame(1'b1, 16, rd);
    check_word(rd, 24'h00_abcd, "16-bit result");
    cfg(adc_cfg_pkg::MODE_NORMAL, 6'h18, 3'h0);
    host_u.read_frame(1'b1, 24, rd);
    check_word(rd, 24'hab_cdef, "24-bit result");
    set_front(24'h13_5791, 24'h00_0000, 24'h00_0000);
    wait_cycles(60);
    check_bit(result_ready_n, 1'b1, "sleep halts");
    cfg(adc_cfg_pkg::MODE_NORMAL, 6'h08, 3'h0);
    wait_cycles(30);
    check_bit(result_ready_n, 1'b0, "new result");
    host_u.read_frame(1'b1, 24, rd);
    check_word(rd, 24'h13_5791, "awake result");
    cfg(adc_cfg_pkg::MODE_ZERO_COEFF, 6'h00, 3'h0);
    host_u.write_frame(1'b1, 24'h5a_5a5a, 24);
    host_u.write_frame(1'b1, 24'hff_ffff, 16);
    host_u.read_frame(1'b1, 24, rd);
    check_word(rd, 24'h5a_5a5a, "zero coeff");
    cfg(adc_cfg_pkg::MODE_FULL_COEFF, 6'h00, 3'h0);
    host_u.write_frame(1'b1, 24'hc3_3c96, 24);
    host_u.read_frame(1'b1, 24, rd);
    check_word(rd, 24'hc3_3c96, "full coeff");
    cfg(adc_cfg_pkg::MODE_ZERO_COEFF, 6'h20, 3'h0);
    host_u.write_frame(1'b1, 24'h11_2233, 24);
    host_u.read_frame(1'b1, 24, rd);
    check_word(rd, 24'h11_2233, "second channel");
    ez = 24'h5a_5a5a;
    ef = 24'hc3_3c96;
    for (int i = 0; i < 5; i++) begin
      m = 3'(i + 1);
      set_front(24'h00_0000, 24'h10_0000 + 24'(i), 24'h20_0000 + 24'(i));
      cfg(m, 6'h00, 3'h0);
      wait_cycles(m == adc_cfg_pkg::MODE_BACKGROUND ? 300 : 80);
      if (m == adc_cfg_pkg::MODE_BACKGROUND) begin
        check_bit(zero_on_shorted, 1'b1, "background zero");
      end else begin
        check_bit(result_ready_n, 1'b0, "cal done");
        host_u.read_frame(1'b0, 24, rd);
        check_word({21'h00_0000, rd[23:21]}, 24'h00_0000, "mode cleared");
      end
      ez = (m == adc_cfg_pkg::MODE_SYS_FULL) ? ez : zero_measure;
      ef = (m == adc_cfg_pkg::MODE_SYS_ZERO) ? ef : full_measure;
      cfg(adc_cfg_pkg::MODE_ZERO_COEFF, 6'h00, 3'h0);
      host_u.read_frame(1'b1, 24, rd);
      check_word(rd, ez, "cal zero");
      cfg(adc_cfg_pkg::MODE_FULL_COEFF, 6'h00, 3'h0);
      host_u.read_frame(1'b1, 24, rd);
      check_word(rd, ef, "cal full");
    end
    test_done();
  end
endmodule : testbench
